// ---- core/dio_pkg.sv ----
package dio_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_OUT_PORT = 8'h00;
  localparam logic [7:0] OFS_BIT_SET = 8'h04;
  localparam logic [7:0] OFS_BIT_CLR = 8'h08;
  localparam logic [7:0] OFS_BLK_DIR = 8'h0c;
  localparam logic [7:0] OFS_EXT_OUT_LO = 8'h10;
  localparam logic [7:0] OFS_EXT_OUT_HI = 8'h14;
  localparam logic [7:0] OFS_IN_W0 = 8'h18;
  localparam logic [7:0] OFS_IN_W1 = 8'h1c;
  localparam logic [7:0] OFS_IN_W2 = 8'h20;
  localparam logic [7:0] OFS_BIT_QUERY = 8'h24;
  localparam logic [7:0] OFS_HOLD = 8'h28;
  localparam logic [7:0] OFS_IRQ_RANGE = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK0 = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK1 = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK2 = 8'h38;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h3c;
  localparam logic [7:0] OFS_STEP_CFG = 8'h40;
  localparam logic [7:0] OFS_AN_SEL = 8'h44;
  localparam logic [7:0] OFS_AN_DATA = 8'h48;
  localparam logic [7:0] OFS_STATUS = 8'h4c;

  // ==========================================================
  // widths and input numbering
  localparam int OUT_W = 8;
  localparam int EXT_W = 40;
  localparam int NBLK = 5;
  localparam int BLK_W = 8;
  localparam int IN_W = 96;
  localparam int AN_W = 12;
  localparam int AN_N = 8;
  localparam int AN_AW = 3;
  localparam int AXES = 8;
  localparam int PC_W = 16;
  localparam int NUM_W = 7;
  localparam logic [NUM_W-1:0] EXT_FIRST = 7'h11;
  localparam logic [NUM_W-1:0] EXT_LAST = 7'h38;
  localparam logic [NUM_W-1:0] IN_LAST = 7'h60;
  localparam int EXT_LSB = 16;
  localparam int GHI_LSB = 56;
  localparam int AUX_LSB = 80;

  // ==========================================================
  // reset values
  localparam logic [OUT_W-1:0] OUT_RST = 8'h00;
  localparam logic [NBLK-1:0] DIR_RST = 5'h00;
  localparam logic [EXT_W-1:0] EXT_RST = 40'h00_0000_0000;
  localparam logic [IN_W-1:0] MASK_RST = 96'h0;
  localparam logic [AXES-1:0] STEP_RST = 8'h00;

  // ==========================================================
  // field positions
  localparam int RANGE_FIRST_LSB = 0;
  localparam int RANGE_LAST_LSB = 8;
  localparam int CTRL_RETURN_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_HANDLER_BIT = 1;
  localparam int STAT_PEND_BIT = 2;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HANDLER = 3'b010,
    ST_RESUME = 3'b100
  } dio_irq_state_t;

endpackage

// ---- core/dio_sample_mem.sv ----
`timescale 1ns/1ps
module dio_sample_mem
  import dio_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [AN_AW-1:0] wr_addr,
  input wire logic [AN_W-1:0] wr_data,
  // read port
  input wire logic [AN_AW-1:0] rd_addr,
  output logic [AN_W-1:0] rd_data
);

  logic [AN_W-1:0] mem [AN_N];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data registered, one cycle behind the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- core/dio_gpio.sv ----
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module dio_gpio
  import dio_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // main output port
  output logic [OUT_W-1:0] out_port,
  // extended i/o pins
  input wire logic [EXT_W-1:0] ext_in,
  output logic [EXT_W-1:0] ext_out,
  output logic [EXT_W-1:0] ext_oe,
  // general input pins (inputs 1-16 and 57-80)
  input wire logic [15:0] gen_in_lo,
  input wire logic [23:0] gen_in_hi,
  // auxiliary encoder pins, one pair per axis
  input wire logic [AXES-1:0] aux_a,
  input wire logic [AXES-1:0] aux_b,
  // converter results, same clock
  input wire logic adc_valid,
  input wire logic [AN_AW-1:0] adc_chan,
  input wire logic [AN_W-1:0] adc_data,
  // program interpreter
  input wire logic [PC_W-1:0] prog_counter,
  output logic hold_busy,
  output logic irq_handler_entry,
  output logic irq_resume_valid,
  output logic [PC_W-1:0] irq_resume_pc
);

  // ==========================================================
  // functions
  function automatic logic [EXT_W-1:0] blk_expand(input logic [NBLK-1:0] d);
    logic [EXT_W-1:0] r;
    r = '0;
    for (int b = 0; b < NBLK; b++) begin
      r[b*BLK_W +: BLK_W] = {BLK_W{d[b]}};
    end
    return r;
  endfunction

  function automatic logic num_ok(input logic [NUM_W-1:0] n, input logic [NUM_W-1:0] lo,
                                  input logic [NUM_W-1:0] hi);
    return (n >= lo) && (n <= hi);
  endfunction

  // ==========================================================
  // input synchroniser
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] sync1_reg;
  logic [IN_W-1:0] sync2_reg;
  logic [IN_W-1:0] level;
  logic [AXES-1:0] step_reg;
  logic [IN_W-1:0] aux_hide;

  always_comb begin
    raw_in = '0;
    aux_hide = '0;
    raw_in[15:0] = gen_in_lo;
    raw_in[EXT_LSB +: EXT_W] = ext_in;
    raw_in[GHI_LSB +: 24] = gen_in_hi;
    for (int a = 0; a < AXES; a++) begin
      raw_in[AUX_LSB + 2*a] = aux_a[a];
      raw_in[AUX_LSB + 2*a + 1] = aux_b[a];
      aux_hide[AUX_LSB + 2*a] = step_reg[a];
      aux_hide[AUX_LSB + 2*a + 1] = step_reg[a];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // stepper axes read as low rather than floating encoder lines
  assign level = sync2_reg & ~aux_hide;

  // ==========================================================
  // apb decode
  logic setup_ph;
  logic wr_en;
  logic hit;
  logic [NUM_W-1:0] wr_num;
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign wr_num = pwdata[NUM_W-1:0];
  assign hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);

  wire wr_out = wr_en && (paddr == OFS_OUT_PORT);
  wire wr_set = wr_en && (paddr == OFS_BIT_SET);
  wire wr_clr = wr_en && (paddr == OFS_BIT_CLR);
  wire wr_dir = wr_en && (paddr == OFS_BLK_DIR);
  wire wr_elo = wr_en && (paddr == OFS_EXT_OUT_LO);
  wire wr_ehi = wr_en && (paddr == OFS_EXT_OUT_HI);
  wire wr_qry = wr_en && (paddr == OFS_BIT_QUERY);
  wire wr_hold = wr_en && (paddr == OFS_HOLD);
  wire wr_rng = wr_en && (paddr == OFS_IRQ_RANGE);
  wire wr_m0 = wr_en && (paddr == OFS_IRQ_MASK0);
  wire wr_m1 = wr_en && (paddr == OFS_IRQ_MASK1);
  wire wr_m2 = wr_en && (paddr == OFS_IRQ_MASK2);
  wire wr_ctl = wr_en && (paddr == OFS_IRQ_CTRL);
  wire wr_step = wr_en && (paddr == OFS_STEP_CFG);
  wire wr_ans = wr_en && (paddr == OFS_AN_SEL);

  // ==========================================================
  // outputs and extended i/o
  logic [OUT_W-1:0] out_reg;
  logic [OUT_W-1:0] out_next;
  logic [NBLK-1:0] dir_reg;
  logic [EXT_W-1:0] ext_reg;
  logic [EXT_W-1:0] ext_next;
  logic [EXT_W-1:0] dir_mask;
  logic [EXT_W-1:0] ext_wdata;
  logic [EXT_W-1:0] ext_wmask;

  assign dir_mask = blk_expand(dir_reg);
  wire set_main = num_ok(wr_num, 7'h01, 7'h08);
  wire set_ext = num_ok(wr_num, EXT_FIRST, EXT_LAST);
  wire [NUM_W-1:0] main_idx = wr_num - 7'h01;
  wire [NUM_W-1:0] ext_idx = wr_num - EXT_FIRST;

  always_comb begin
    out_next = out_reg;
    if (wr_out) begin
      out_next = pwdata[OUT_W-1:0];
    end else if (wr_set && set_main) begin
      out_next[main_idx[2:0]] = 1'b1;
    end else if (wr_clr && set_main) begin
      out_next[main_idx[2:0]] = 1'b0;
    end
  end

  always_comb begin
    ext_wdata = '0;
    ext_wmask = '0;
    if (wr_elo) begin
      ext_wdata[31:0] = pwdata;
      ext_wmask[31:0] = '1;
    end else if (wr_ehi) begin
      ext_wdata[EXT_W-1:32] = pwdata[7:0];
      ext_wmask[EXT_W-1:32] = '1;
    end else if ((wr_set || wr_clr) && set_ext) begin
      ext_wdata[ext_idx[5:0]] = wr_set;
      ext_wmask[ext_idx[5:0]] = 1'b1;
    end
    // points in input blocks keep their value
    ext_wmask = ext_wmask & dir_mask;
    ext_next = (ext_reg & ~ext_wmask) | (ext_wdata & ext_wmask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= OUT_RST;
      dir_reg <= DIR_RST;
      ext_reg <= EXT_RST;
      step_reg <= STEP_RST;
    end else begin
      out_reg <= out_next;
      ext_reg <= ext_next;
      if (wr_dir) begin
        dir_reg <= pwdata[NBLK-1:0];
      end
      if (wr_step) begin
        step_reg <= pwdata[AXES-1:0];
      end
    end
  end

  assign out_port = out_reg;
  assign ext_out = ext_reg & dir_mask;
  assign ext_oe = dir_mask;

  // ==========================================================
  // single input query and hold wait
  logic [NUM_W-1:0] qry_reg;
  logic [7:0] hold_reg;
  logic hold_reg_busy;
  wire [7:0] hold_mag8 = hold_reg[7] ? (8'h00 - hold_reg) : hold_reg;
  wire [NUM_W-1:0] hold_mag = hold_mag8[NUM_W-1:0];
  wire [NUM_W-1:0] hold_idx = hold_mag - 7'h01;
  wire [7:0] new_mag = pwdata[7] ? (8'h00 - pwdata[7:0]) : pwdata[7:0];
  wire new_ok = (new_mag[7] == 1'b0) && num_ok(new_mag[NUM_W-1:0], 7'h01, IN_LAST);
  wire qry_ok = num_ok(qry_reg, 7'h01, IN_LAST);
  wire [NUM_W-1:0] qry_idx = qry_reg - 7'h01;
  wire qry_level = qry_ok && level[qry_idx];
  wire hold_met = (level[hold_idx] == !hold_reg[7]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qry_reg <= '0;
      hold_reg <= '0;
      hold_reg_busy <= 1'b0;
    end else begin
      if (wr_qry) begin
        qry_reg <= wr_num;
      end
      if (wr_hold) begin
        hold_reg <= pwdata[7:0];
        hold_reg_busy <= new_ok;
      end else if (hold_reg_busy && hold_met) begin
        hold_reg_busy <= 1'b0;
      end
    end
  end

  assign hold_busy = hold_reg_busy;

  // ==========================================================
  // analog samples
  logic [AN_AW-1:0] an_sel_reg;
  logic [AN_W-1:0] an_rdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_sel_reg <= '0;
    end else if (wr_ans && num_ok(wr_num, 7'h01, 7'h08)) begin
      an_sel_reg <= main_idx[AN_AW-1:0];
    end
  end

  dio_sample_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(adc_valid),
    .wr_addr(adc_chan),
    .wr_data(adc_data),
    .rd_addr(an_sel_reg),
    .rd_data(an_rdata)
  );

  // ==========================================================
  // input interrupt
  logic [IN_W-1:0] mask_reg;
  logic [IN_W-1:0] range_mask;
  logic [IN_W-1:0] mask_next;
  dio_irq_state_t st_reg;
  dio_irq_state_t st_next;
  logic [PC_W-1:0] pc_reg;
  logic entry_reg;
  wire [NUM_W-1:0] rng_first = pwdata[RANGE_FIRST_LSB +: NUM_W];
  wire [NUM_W-1:0] rng_last = pwdata[RANGE_LAST_LSB +: NUM_W];

  always_comb begin
    range_mask = '0;
    for (int i = 0; i < IN_W; i++) begin
      range_mask[i] = num_ok(7'(i + 1), rng_first, rng_last);
    end
  end

  always_comb begin
    mask_next = mask_reg;
    if (wr_rng && (rng_first != '0) && (rng_last != '0)) begin
      mask_next = range_mask;
    end else if (wr_m0) begin
      mask_next[31:0] = pwdata;
    end else if (wr_m1) begin
      mask_next[63:32] = pwdata;
    end else if (wr_m2) begin
      mask_next[95:64] = pwdata;
    end
  end

  wire irq_hit = |(mask_reg & ~level);
  wire do_return = wr_ctl && pwdata[CTRL_RETURN_BIT];
  wire do_clear = wr_ctl && pwdata[CTRL_CLEAR_BIT];

  always_comb begin
    case (st_reg)
      ST_RUN: st_next = irq_hit ? ST_HANDLER : ST_RUN;
      ST_HANDLER: begin
        if (do_clear) begin
          st_next = ST_RUN;
        end else if (do_return) begin
          st_next = ST_RESUME;
        end else begin
          st_next = ST_HANDLER;
        end
      end
      ST_RESUME: st_next = ST_RUN;
      default: st_next = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= MASK_RST;
      st_reg <= ST_RUN;
      pc_reg <= '0;
      entry_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      st_reg <= st_next;
      entry_reg <= (st_reg == ST_RUN) && irq_hit;
      if ((st_reg == ST_RUN) && irq_hit) begin
        pc_reg <= prog_counter;
      end
    end
  end

  assign irq_handler_entry = entry_reg;
  assign irq_resume_valid = (st_reg == ST_RESUME);
  assign irq_resume_pc = pc_reg;

  // ==========================================================
  // read mux, captured in the setup phase for a zero-wait access
  logic [31:0] rd_mux;
  logic [31:0] rdata_reg;
  logic err_reg;

  always_comb begin
    rd_mux = '0;
    case (paddr)
      OFS_OUT_PORT: rd_mux[OUT_W-1:0] = out_reg;
      OFS_BLK_DIR: rd_mux[NBLK-1:0] = dir_reg;
      OFS_EXT_OUT_LO: rd_mux = ext_reg[31:0];
      OFS_EXT_OUT_HI: rd_mux[7:0] = ext_reg[EXT_W-1:32];
      OFS_IN_W0: rd_mux = level[31:0];
      OFS_IN_W1: rd_mux = level[63:32];
      OFS_IN_W2: rd_mux = level[95:64];
      OFS_BIT_QUERY: rd_mux = {qry_level, 24'h00_0000, qry_reg};
      OFS_HOLD: rd_mux[7:0] = hold_reg;
      OFS_IRQ_MASK0: rd_mux = mask_reg[31:0];
      OFS_IRQ_MASK1: rd_mux = mask_reg[63:32];
      OFS_IRQ_MASK2: rd_mux = mask_reg[95:64];
      OFS_STEP_CFG: rd_mux[AXES-1:0] = step_reg;
      OFS_AN_SEL: rd_mux[AN_AW-1:0] = an_sel_reg;
      OFS_AN_DATA: rd_mux[AN_W-1:0] = an_rdata;
      OFS_STATUS: begin
        rd_mux[STAT_HOLD_BIT] = hold_reg_busy;
        rd_mux[STAT_HANDLER_BIT] = (st_reg == ST_HANDLER);
        rd_mux[STAT_PEND_BIT] = irq_hit;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else if (setup_ph) begin
      rdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      err_reg <= !hit;
    end
  end

  assign prdata = rdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_reg;

endmodule

// ---- dv/dio_props.sv ----
`timescale 1ns/1ps
module dio_props
  import dio_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // pins
  input wire logic [OUT_W-1:0] out_port,
  input wire logic [EXT_W-1:0] ext_out,
  input wire logic [EXT_W-1:0] ext_oe,
  input wire logic irq_handler_entry,
  input wire logic irq_resume_valid
);
  // ========
  // write decode
  wire wr = psel && penable && pwrite;
  wire [7:0] bit_hot = 8'h01 << (pwdata[3:0] - 4'h1);
  wire low8 = (pwdata >= 32'h1) && (pwdata <= 32'h8);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ========
  // properties
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_port_whole: assert property (wr && paddr == OFS_OUT_PORT |=> out_port == $past(pwdata[7:0]))
    else $error("output port not equal to written word");
  a_bit_set_only: assert property (wr && paddr == OFS_BIT_SET && low8 |=>
    out_port == ($past(out_port) | $past(bit_hot)))
    else $error("single set disturbed other outputs");
  a_bit_clr_only: assert property (wr && paddr == OFS_BIT_CLR && low8 |=>
    out_port == ($past(out_port) & ~$past(bit_hot)))
    else $error("single clear disturbed other outputs");
  a_dir_to_oe: assert property (wr && paddr == OFS_BLK_DIR |=> ext_oe == {{8{$past(pwdata[4])}},
    {8{$past(pwdata[3])}}, {8{$past(pwdata[2])}}, {8{$past(pwdata[1])}}, {8{$past(pwdata[0])}}})
    else $error("block enables differ from direction");
  a_input_quiet: assert property (wr && paddr == OFS_EXT_OUT_LO |=>
    ext_out[31:0] == $past(pwdata & ext_oe[31:0]))
    else $error("write reached a point in an input block");
  a_entry_pulse: assert property (irq_handler_entry |=> !irq_handler_entry)
    else $error("handler entry longer than one cycle");
  a_resume_cause: assert property (irq_resume_valid |->
    $past(wr && paddr == OFS_IRQ_CTRL && pwdata[1:0] == 2'b01))
    else $error("resume without return write");
  // ========
  // coverage
  c_entry: cover property (irq_handler_entry);
  c_resume: cover property (irq_resume_valid);
  c_clr: cover property (wr && paddr == OFS_BIT_CLR && low8);
endmodule

bind dio_gpio dio_props i_dio_props (.*);

// ---- dv/dio_field.sv ----
`timescale 1ns/1ps
module dio_field
  import dio_pkg::*;
(
  // wanted levels, bit n-1 is input n
  input wire logic [IN_W-1:0] lvl,
  // device pins
  input wire logic [EXT_W-1:0] ext_out,
  input wire logic [EXT_W-1:0] ext_oe,
  output logic [EXT_W-1:0] ext_in,
  output logic [15:0] gen_in_lo,
  output logic [23:0] gen_in_hi,
  output logic [AXES-1:0] aux_a,
  output logic [AXES-1:0] aux_b
);
  // an output block reads back what the device drives
  assign ext_in = (ext_oe & ext_out) | (~ext_oe & lvl[EXT_LSB +: EXT_W]);
  assign gen_in_lo = lvl[15:0];
  assign gen_in_hi = lvl[GHI_LSB +: 24];
  for (genvar k = 0; k < AXES; k++) begin : g_aux
    assign aux_a[k] = lvl[AUX_LSB + 2 * k];
    assign aux_b[k] = lvl[AUX_LSB + 2 * k + 1];
  end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import dio_pkg::*;
  typedef struct {string nm; logic [31:0] d; logic e;} dio_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic adc_valid = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, hold_busy, irq_handler_entry, irq_resume_valid;
  logic [OUT_W-1:0] out_port;
  logic [EXT_W-1:0] ext_in, ext_out, ext_oe;
  logic [15:0] gen_in_lo;
  logic [23:0] gen_in_hi;
  logic [AXES-1:0] aux_a, aux_b;
  logic [AN_AW-1:0] adc_chan = 3'h0;
  logic [AN_W-1:0] adc_data = 12'h000;
  logic [PC_W-1:0] prog_counter = 16'h0000;
  logic [PC_W-1:0] irq_resume_pc;
  logic [IN_W-1:0] lvl = {IN_W{1'b1}};
  logic [AN_W-1:0] smp [AN_N];
  dio_note_t notes [$];
  dio_note_t nt;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 73;
  int i;
  int qn [5] = '{1, 40, 81, 82, 96};
  logic [31:0] wv;

  always #2.5 pclk = ~pclk;

  dio_gpio i_dio_gpio (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .out_port(out_port), .ext_in(ext_in), .ext_out(ext_out),
    .ext_oe(ext_oe), .gen_in_lo(gen_in_lo), .gen_in_hi(gen_in_hi), .aux_a(aux_a),
    .aux_b(aux_b), .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data),
    .prog_counter(prog_counter), .hold_busy(hold_busy),
    .irq_handler_entry(irq_handler_entry), .irq_resume_valid(irq_resume_valid),
    .irq_resume_pc(irq_resume_pc));
  dio_field i_dio_field (.lvl(lvl), .ext_out(ext_out), .ext_oe(ext_oe), .ext_in(ext_in),
    .gen_in_lo(gen_in_lo), .gen_in_hi(gen_in_hi), .aux_a(aux_a), .aux_b(aux_b));

  // ========
  // helpers
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(string nm, logic [63:0] exp, logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_fail++;
        conclude();
      end
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [31:0] d, logic e = 1'b0);
    notes.push_back('{nm, d, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic setl(int k, logic v);
    @(posedge pclk);
    lvl[k] <= v;
  endtask
  // bounded wait: 0 entry, 1 resume, 2 hold finished
  task automatic wait_for(int k);
    for (int n = 0; n < 20; n++) begin
      // one-cycle pulses may already stand when the call starts
      #1;
      if ((k == 0 && irq_handler_entry === 1'b1) || (k == 1 && irq_resume_valid === 1'b1)
          || (k == 2 && hold_busy === 1'b0)) return;
      @(posedge pclk);
    end
    n_fail++;
    conclude();
  endtask
  task automatic hold(logic [7:0] code, int k, logic v);
    setl(k, !v);
    repeat (3) @(posedge pclk);
    apb(1'b1, OFS_HOLD, {24'h0, code});
    @(posedge pclk);
    #1;
    cmp("hold_busy", 1, hold_busy);
    setl(k, v);
    wait_for(2);
  endtask

  // ========
  // read results, oldest note first
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (notes.size() == 0) cmp("note queue", 1, 0);
      else begin
        nt = notes.pop_front();
        cmp(nt.nm, nt.d, prdata);
        cmp(nt.nm, nt.e, pslverr);
      end
    end
  end

  initial begin
    #200us;
    n_fail++;
    conclude();
  end

  // ========
  // scenarios
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    cmp("ext_oe", 0, ext_oe);
    rd("dir", OFS_BLK_DIR, 0);
    for (i = 0; i < 6; i++) begin
      wv = (i == 0) ? 6 : (i == 1) ? 0 : (i == 2) ? 255 : $random(seed) & 255;
      apb(1'b1, OFS_OUT_PORT, wv);
      #1;
      cmp("out_port", wv, out_port);
    end
    apb(1'b1, OFS_OUT_PORT, 0);
    for (i = 1; i <= 8; i++) begin
      apb(1'b1, OFS_BIT_SET, i);
      #1;
      cmp("out_port", (1 << i) - 1, out_port);
    end
    apb(1'b1, OFS_BIT_CLR, 3);
    #1;
    cmp("out_port", 8'hfb, out_port);
    apb(1'b1, OFS_BIT_SET, 17);
    apb(1'b1, OFS_BLK_DIR, 32'h0c);
    #1;
    cmp("ext_oe", 40'h00_ffff_0000, ext_oe);
    apb(1'b1, OFS_EXT_OUT_LO, 32'hffff_ffff);
    apb(1'b1, OFS_BIT_CLR, 33);
    #1;
    cmp("ext_out", 40'h00_fffe_0000, ext_out);
    rd("ext lo", OFS_EXT_OUT_LO, 32'hfffe_0000);
    apb(1'b1, OFS_BLK_DIR, 0);
    @(posedge pclk);
    lvl <= {$random(seed), $random(seed), $random(seed)};
    repeat (3) @(posedge pclk);
    rd("in w0", OFS_IN_W0, lvl[31:0]);
    rd("in w1", OFS_IN_W1, lvl[63:32]);
    rd("in w2", OFS_IN_W2, lvl[95:64]);
    foreach (qn[j]) begin
      i = qn[j];
      apb(1'b1, OFS_BIT_QUERY, i);
      rd("query", OFS_BIT_QUERY, {lvl[i-1], 24'h0, i[6:0]});
    end
    apb(1'b1, OFS_STEP_CFG, 1);
    rd("in w2 step", OFS_IN_W2, lvl[95:64] & 32'hfffc_ffff);
    apb(1'b1, OFS_STEP_CFG, 0);
    hold(8'h07, 6, 1'b1);
    hold(8'hfa, 5, 1'b0);
    for (i = 0; i < AN_N; i++) begin
      @(posedge pclk);
      smp[i] = 12'($random(seed));
      adc_valid <= 1'b1;
      adc_chan <= i[2:0];
      adc_data <= smp[i];
    end
    @(posedge pclk);
    adc_valid <= 1'b0;
    for (i = 0; i < AN_N; i++) begin
      apb(1'b1, OFS_AN_SEL, i + 1);
      rd("analog", OFS_AN_DATA, {20'h0, smp[i]});
    end
    apb(1'b1, OFS_AN_SEL, 9);
    rd("an sel", OFS_AN_SEL, 7);
    @(posedge pclk);
    lvl <= {IN_W{1'b1}};
    prog_counter <= 16'($random(seed));
    apb(1'b1, OFS_IRQ_MASK0, 5);
    rd("mask0", OFS_IRQ_MASK0, 5);
    setl(2, 1'b0);
    wait_for(0);
    setl(2, 1'b1);
    apb(1'b1, OFS_IRQ_CTRL, 1);
    wait_for(1);
    cmp("resume pc", prog_counter, irq_resume_pc);
    apb(1'b1, OFS_IRQ_RANGE, 32'h0c0a);
    rd("mask0 range", OFS_IRQ_MASK0, 32'h0e00);
    setl(10, 1'b0);
    wait_for(0);
    setl(10, 1'b1);
    repeat (3) @(posedge pclk);
    apb(1'b1, OFS_IRQ_CTRL, 2);
    #1;
    cmp("resume", 0, irq_resume_valid);
    rd("status", OFS_STATUS, 0);
    rd("unmapped", 8'h80, 0, 1'b1);
    repeat (2) @(posedge pclk);
    conclude();
  end
endmodule
